// >>> pkg/cycle_if.sv
// Request and answer carrier between sequencer and pin engine
`timescale 1ns/1ns
interface cycle_if;
    logic        req;    // One-cycle request
    logic        wr;     // Write when high
    logic [14:0] addr;   // Byte address
    logic [7:0]  wdata;  // Write byte
    logic        done;   // One-cycle completion
    logic [7:0]  rdata;  // Byte read

    modport master (output req, output wr, output addr, output wdata,
                    input done, input rdata);
    modport engine (input req, input wr, input addr, input wdata,
                    output done, output rdata);
endinterface

// >>> pkg/nv_host_defines.svh
// Constants for the store/recall host controller
`ifndef NV_HOST_DEFINES_SVH
`define NV_HOST_DEFINES_SVH

// ****************************************
// Register map (APB byte addresses)
// ****************************************
`define REG_CTRL        8'h00
`define REG_ADDR        8'h04
`define REG_WDATA       8'h08
`define REG_STATUS      8'h0C
`define REG_RDATA       8'h10

// Field positions
`define CTRL_OP_HI      2
`define ST_BUSY         0
`define ST_DEV_BUSY     1
`define ST_AUTO_EN      2
`define ST_REFUSED      3
`define ADDR_HI         14
`define DATA_HI         7

// Reset values
`define AUTO_EN_RST     1'b1
`define ZERO32          32'h0000_0000

// ****************************************
// Command addresses, bit 14 always zero
// ****************************************
`define SEQ_A0          15'h0E38
`define SEQ_A1          15'h31C7
`define SEQ_A2          15'h03E0
`define SEQ_A3          15'h3C1F
`define SEQ_A4          15'h303F
`define SEQ_STORE       15'h0FC0
`define SEQ_RECALL      15'h0C63
`define SEQ_AUTO_OFF    15'h03F8
`define SEQ_AUTO_ON     15'h07F0
`define SEQ_LAST        3'h5

// ****************************************
// Timing
// ****************************************
`define CLK_NS          100
`define CYCLE_NS        45
`define HSB_PULSE_NS    15
`define TSS_US          70
`define RECALL_US       50
`define STROBE_CYC      2'h3
`define HSB_PULSE_CYC   (((`HSB_PULSE_NS) + `CLK_NS - 1) / `CLK_NS)
`define TSS_CYC         ((`TSS_US * 1000) / `CLK_NS)
`define RECALL_CYC      ((`RECALL_US * 1000) / `CLK_NS)
`define WAIT_W          11
`endif

// >>> pkg/nv_host_pkg.sv
// Types shared by the store/recall host controller
package nv_host_pkg;
    // Operation codes written to the control register
    typedef enum logic [2:0] {
        OP_NONE     = 3'h0,
        OP_READ     = 3'h1,
        OP_WRITE    = 3'h2,
        OP_STORE    = 3'h3,
        OP_RECALL   = 3'h4,
        OP_AUTO_ON  = 3'h5,
        OP_AUTO_OFF = 3'h6,
        OP_HW_STORE = 3'h7
    } op_t;

    // Command sequencer states
    typedef enum logic [5:0] {
        C_IDLE  = 6'h01,
        C_SEQ   = 6'h02,
        C_CYC   = 6'h04,
        C_PULSE = 6'h08,
        C_WAIT  = 6'h10,
        C_BUSYW = 6'h20
    } ctl_state_t;

    // Pin cycle engine states
    typedef enum logic [3:0] {
        E_IDLE    = 4'h1,
        E_SETUP   = 4'h2,
        E_STROBE  = 4'h4,
        E_RECOVER = 4'h8
    } eng_state_t;
endpackage

// >>> src/nvsram_host_ctrl.sv
// APB-controlled host for a store/recall static RAM
//
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/1ns
`include "nv_host_defines.svh"
module nvsram_host_ctrl
    import nv_host_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Memory pins
    output logic             ce_n,
    output logic             we_n,
    output logic             oe_n,
    output logic [14:0]      mem_addr,
    output logic [7:0]       data_o,
    output logic             data_oe_n,
    input  wire logic [7:0]  data_i,
    // Store/busy pin, open drain
    output logic             hw_store_busy_n_o,
    output logic             hw_store_busy_n_oe_n,
    input  wire logic        hw_store_busy_n_i
);
    // ****************************************
    // Declarations
    // ****************************************
    cycle_if cyc ();                          // Carrier to pin engine
    ctl_state_t       st_r,   st_nxt;        // Sequencer state
    op_t              op_r,   op_nxt;        // Running operation
    logic [2:0]       stp_r,  stp_nxt;       // Sequence step
    logic [`WAIT_W-1:0] cnt_r, cnt_nxt;      // Wait counter
    logic [14:0]      adr_r,  adr_nxt;       // Address register
    logic [7:0]       wd_r,   wd_nxt;        // Write data register
    logic [7:0]       rd_r,   rd_nxt;        // Read data register
    logic             aen_r,  aen_nxt;       // Automatic store setting record
    logic             ref_r,  ref_nxt;       // Refused command flag
    logic             drv_r,  drv_nxt;       // Driving busy pin low
    logic [31:0]      prd_r,  prd_nxt;       // APB read data
    logic             req_nxt;               // Cycle request
    logic             h1_r,   h2_r;          // Busy pin synchroniser
    logic [14:0]      seq_a;                 // Address of current step
    logic             apb_wr, apb_rd, known; // Decoded bus phases
    op_t              wop;                   // Written operation

    assign apb_wr = psel && penable && pwrite;
    assign apb_rd = psel && !penable && !pwrite;
    assign known  = (paddr == `REG_CTRL)   || (paddr == `REG_ADDR) ||
                    (paddr == `REG_WDATA)  || (paddr == `REG_STATUS) ||
                    (paddr == `REG_RDATA);
    assign wop    = op_t'(pwdata[`CTRL_OP_HI:0]);

    // Command address for each step of a sequence
    always_comb begin
        unique case (stp_r)
            3'h0: seq_a = `SEQ_A0;
            3'h1: seq_a = `SEQ_A1;
            3'h2: seq_a = `SEQ_A2;
            3'h3: seq_a = `SEQ_A3;
            3'h4: seq_a = `SEQ_A4;
            default: begin
                unique case (op_r)
                    OP_STORE:    seq_a = `SEQ_STORE;
                    OP_RECALL:   seq_a = `SEQ_RECALL;
                    OP_AUTO_OFF: seq_a = `SEQ_AUTO_OFF;
                    default:     seq_a = `SEQ_AUTO_ON;
                endcase
            end
        endcase
    end

    // ****************************************
    // Sequencer and registers, next values
    // ****************************************
    always_comb begin
        st_nxt  = st_r;
        op_nxt  = op_r;
        stp_nxt = stp_r;
        cnt_nxt = cnt_r;
        adr_nxt = adr_r;
        wd_nxt  = wd_r;
        rd_nxt  = rd_r;
        aen_nxt = aen_r;
        ref_nxt = ref_r;
        req_nxt = 1'b0;
        prd_nxt = prd_r;
        // Register writes take effect in the access phase, when pready is seen
        if (apb_wr && paddr == `REG_ADDR) begin
            adr_nxt = pwdata[`ADDR_HI:0];
        end
        if (apb_wr && paddr == `REG_WDATA) begin
            wd_nxt = pwdata[`DATA_HI:0];
        end
        // Reading status clears the refused flag
        if (apb_rd && paddr == `REG_STATUS) begin
            ref_nxt = 1'b0;
        end
        unique case (st_r)
            C_IDLE: begin
                // Device busy also refuses new work
                if (apb_wr && paddr == `REG_CTRL && wop != OP_NONE) begin
                    op_nxt  = wop;
                    stp_nxt = 3'h0;
                    if (!h2_r) begin
                        ref_nxt = 1'b1;
                        st_nxt  = C_IDLE;
                    end else if (wop == OP_READ || wop == OP_WRITE) begin
                        st_nxt = C_SEQ;
                    end else if (wop == OP_HW_STORE) begin
                        cnt_nxt = `WAIT_W'(`HSB_PULSE_CYC - 1);
                        st_nxt  = C_PULSE;
                    end else begin
                        st_nxt = C_SEQ;
                    end
                end
            end
            C_SEQ: begin
                // Issue one pin cycle; sequence steps are reads only
                req_nxt = 1'b1;
                st_nxt  = C_CYC;
            end
            C_CYC: begin
                if (cyc.done) begin
                    if (!cyc.wr) begin
                        rd_nxt = cyc.rdata;
                    end
                    if (op_r == OP_READ || op_r == OP_WRITE) begin
                        st_nxt = C_IDLE;
                    end else if (stp_r == `SEQ_LAST) begin
                        // Allow command processing, plus recall lockout
                        if (op_r == OP_RECALL) begin
                            cnt_nxt = `WAIT_W'(`TSS_CYC + `RECALL_CYC);
                        end else begin
                            cnt_nxt = `WAIT_W'(`TSS_CYC);
                        end
                        if (op_r == OP_AUTO_ON) begin
                            aen_nxt = 1'b1;
                        end else if (op_r == OP_AUTO_OFF) begin
                            aen_nxt = 1'b0;
                        end
                        st_nxt = C_WAIT;
                    end else begin
                        stp_nxt = stp_r + 3'h1;
                        st_nxt  = C_SEQ;
                    end
                end
            end
            C_PULSE: begin
                // Busy pin held low for the request pulse
                if (cnt_r == `WAIT_W'(0)) begin
                    cnt_nxt = `WAIT_W'(`TSS_CYC);
                    st_nxt  = C_WAIT;
                end else begin
                    cnt_nxt = cnt_r - `WAIT_W'(1);
                end
            end
            C_WAIT: begin
                // Latency before the device shows busy
                if (cnt_r == `WAIT_W'(0)) begin
                    st_nxt = C_BUSYW;
                end else begin
                    cnt_nxt = cnt_r - `WAIT_W'(1);
                end
            end
            C_BUSYW: begin
                // Wait while the device pulls the pin low for a store
                if (h2_r) begin
                    st_nxt = C_IDLE;
                end
            end
            default: begin
                st_nxt = C_IDLE;
            end
        endcase
        // A refusal in the same cycle as the clear still sticks
        if (apb_wr && paddr == `REG_CTRL && st_r != C_IDLE) begin
            ref_nxt = 1'b1;
        end
        drv_nxt = (st_nxt == C_PULSE);
        // Read data is captured in the setup phase
        if (apb_rd) begin
            prd_nxt = `ZERO32;
            unique case (paddr)
                `REG_CTRL:   prd_nxt[`CTRL_OP_HI:0] = op_r;
                `REG_ADDR:   prd_nxt[`ADDR_HI:0]    = adr_r;
                `REG_WDATA:  prd_nxt[`DATA_HI:0]    = wd_r;
                `REG_RDATA:  prd_nxt[`DATA_HI:0]    = rd_r;
                `REG_STATUS: begin
                    prd_nxt[`ST_BUSY]     = (st_r != C_IDLE);
                    prd_nxt[`ST_DEV_BUSY] = !h2_r;
                    prd_nxt[`ST_AUTO_EN]  = aen_r;
                    prd_nxt[`ST_REFUSED]  = ref_r;
                end
                default:     prd_nxt = `ZERO32;
            endcase
        end
    end

    // Registers of the sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r      <= C_IDLE;
            op_r      <= OP_NONE;
            stp_r     <= 3'h0;
            cnt_r     <= `WAIT_W'(0);
            adr_r     <= 15'h0000;
            wd_r      <= 8'h00;
            rd_r      <= 8'h00;
            aen_r     <= `AUTO_EN_RST;
            ref_r     <= 1'b0;
            drv_r     <= 1'b0;
            prd_r     <= `ZERO32;
            cyc.req   <= 1'b0;
            cyc.wr    <= 1'b0;
            cyc.addr  <= 15'h0000;
            cyc.wdata <= 8'h00;
            h1_r      <= 1'b1;
            h2_r      <= 1'b1;
        end else begin
            st_r      <= st_nxt;
            op_r      <= op_nxt;
            stp_r     <= stp_nxt;
            cnt_r     <= cnt_nxt;
            adr_r     <= adr_nxt;
            wd_r      <= wd_nxt;
            rd_r      <= rd_nxt;
            aen_r     <= aen_nxt;
            ref_r     <= ref_nxt;
            drv_r     <= drv_nxt;
            prd_r     <= prd_nxt;
            cyc.req   <= req_nxt;
            cyc.wr    <= (op_r == OP_WRITE);
            cyc.addr  <= (op_r == OP_READ || op_r == OP_WRITE) ? adr_r : seq_a;
            cyc.wdata <= wd_r;
            h1_r      <= hw_store_busy_n_i;
            h2_r      <= h1_r;
        end
    end

    // ****************************************
    // Bus answer and pin engine
    // ****************************************
    assign prdata               = prd_r;
    assign pready               = 1'b1;
    assign pslverr              = psel && penable && !known;
    assign hw_store_busy_n_o    = 1'b0;
    assign hw_store_busy_n_oe_n = !drv_r;

    pin_cycle_engine u_engine (
        .pclk      (pclk),
        .presetn   (presetn),
        .cyc       (cyc.engine),
        .ce_n      (ce_n),
        .we_n      (we_n),
        .oe_n      (oe_n),
        .mem_addr  (mem_addr),
        .data_o    (data_o),
        .data_oe_n (data_oe_n),
        .data_i    (data_i)
    );

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    seq_step_order_a: assert property ((st_r == C_CYC && cyc.done && op_r > OP_WRITE
        && stp_r != `SEQ_LAST) |=> st_r == C_SEQ && stp_r == $past(stp_r) + 3'h1)
        else $error("sequence step skipped or repeated");
    seq_no_write_a: assert property ((st_r == C_CYC && op_r > OP_WRITE) |-> !cyc.wr)
        else $error("write issued inside a command sequence");
    seq_first_addr_a: assert property ((st_r == C_SEQ && stp_r == 3'h0
        && op_r > OP_WRITE) |=> cyc.req && cyc.addr == `SEQ_A0)
        else $error("sequence did not start at first address");
endmodule // nvsram_host_ctrl

// >>> src/pin_cycle_engine.sv
// Runs one select-controlled read or write cycle on the memory pins
`timescale 1ns/1ns
`include "nv_host_defines.svh"
module pin_cycle_engine
    import nv_host_pkg::*;
(
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Sequencer side
    cycle_if.engine         cyc,
    // Memory pins
    output logic            ce_n,
    output logic            we_n,
    output logic            oe_n,
    output logic [14:0]     mem_addr,
    output logic [7:0]      data_o,
    output logic            data_oe_n,
    input  wire logic [7:0] data_i
);
    // ****************************************
    // State
    // ****************************************
    eng_state_t  st_r,  st_nxt;     // Engine state
    logic [1:0]  cnt_r, cnt_nxt;    // Strobe length counter
    logic        wr_r,  wr_nxt;     // Cycle is a write
    logic        ce_r,  ce_nxt;     // Select, active low
    logic        we_r,  we_nxt;     // Write strobe, active low
    logic        oe_r,  oe_nxt;     // Output enable, active low
    logic [14:0] a_r,   a_nxt;      // Address latch
    logic [7:0]  d_r,   d_nxt;      // Write data latch
    logic        doe_r, doe_nxt;    // Data drive enable, low drives
    logic [7:0]  rd_r,  rd_nxt;     // Captured read byte
    logic        dn_r,  dn_nxt;     // Done pulse
    logic [7:0]  s1_r,  s2_r;       // Data input synchroniser

    // Next-state logic for one bus cycle
    always_comb begin
        st_nxt  = st_r;
        cnt_nxt = cnt_r;
        wr_nxt  = wr_r;
        ce_nxt  = ce_r;
        we_nxt  = we_r;
        oe_nxt  = oe_r;
        a_nxt   = a_r;
        d_nxt   = d_r;
        doe_nxt = doe_r;
        rd_nxt  = rd_r;
        dn_nxt  = 1'b0;
        unique case (st_r)
            E_IDLE: begin
                // Latch request; select stays high so the next fall is fresh
                if (cyc.req) begin
                    a_nxt   = cyc.addr;
                    d_nxt   = cyc.wdata;
                    wr_nxt  = cyc.wr;
                    doe_nxt = !cyc.wr;
                    st_nxt  = E_SETUP;
                end
            end
            E_SETUP: begin
                // Address settled, open the strobe
                ce_nxt  = 1'b0;
                we_nxt  = !wr_r;
                oe_nxt  = wr_r;
                cnt_nxt = `STROBE_CYC - 2'h1;
                st_nxt  = E_STROBE;
            end
            E_STROBE: begin
                if (cnt_r == 2'h0) begin
                    // Strobe long enough for the synchroniser to see data
                    if (!wr_r) begin
                        rd_nxt = s2_r;
                    end
                    ce_nxt = 1'b1;
                    we_nxt = 1'b1;
                    oe_nxt = 1'b1;
                    dn_nxt = 1'b1;
                    st_nxt = E_RECOVER;
                end else begin
                    cnt_nxt = cnt_r - 2'h1;
                end
            end
            E_RECOVER: begin
                // Data released one clock after the strobe ends for hold
                doe_nxt = 1'b1;
                st_nxt  = E_IDLE;
            end
            default: begin
                st_nxt = E_IDLE;
            end
        endcase
    end

    // Registers of the engine
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r  <= E_IDLE;
            cnt_r <= 2'h0;
            wr_r  <= 1'b0;
            ce_r  <= 1'b1;
            we_r  <= 1'b1;
            oe_r  <= 1'b1;
            a_r   <= 15'h0000;
            d_r   <= 8'h00;
            doe_r <= 1'b1;
            rd_r  <= 8'h00;
            dn_r  <= 1'b0;
            s1_r  <= 8'h00;
            s2_r  <= 8'h00;
        end else begin
            st_r  <= st_nxt;
            cnt_r <= cnt_nxt;
            wr_r  <= wr_nxt;
            ce_r  <= ce_nxt;
            we_r  <= we_nxt;
            oe_r  <= oe_nxt;
            a_r   <= a_nxt;
            d_r   <= d_nxt;
            doe_r <= doe_nxt;
            rd_r  <= rd_nxt;
            dn_r  <= dn_nxt;
            s1_r  <= data_i;
            s2_r  <= s1_r;
        end
    end

    // Outputs straight from flops
    assign ce_n      = ce_r;
    assign we_n      = we_r;
    assign oe_n      = oe_r;
    assign mem_addr  = a_r;
    assign data_o    = d_r;
    assign data_oe_n = doe_r;
    assign cyc.done  = dn_r;
    assign cyc.rdata = rd_r;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_strobe;
        !ce_r [*3];
    endsequence
    sequence s_gap;
        ce_r [*3];
    endsequence

    strobe_spacing_a: assert property ($fell(ce_r) |-> s_strobe ##1 s_gap)
        else $error("select strobe width or gap wrong");
    write_oe_high_a: assert property (!we_r |-> oe_r && !doe_r && $stable(d_r))
        else $error("output enable low or data moving during write");
    read_we_high_a: assert property ((!ce_r && !wr_r) |-> we_r && !oe_r)
        else $error("write strobe low during read cycle");
endmodule // pin_cycle_engine

// >>> tb/nv_device_model.sv
// Behavioural store/recall static RAM that answers the host pins
`timescale 1ns/1ns
module nv_device_model #(
    parameter int LAT_NS    = 1000,   // Pin request to store start
    parameter int STORE_NS  = 20000,  // Store length
    parameter int RECALL_NS = 40000   // Recall length
) (
    // Memory pins
    input  wire logic        ce_n,
    input  wire logic        we_n,
    input  wire logic        oe_n,
    input  wire logic [14:0] addr,
    input  wire logic [7:0]  din,
    input  wire logic        hsb_n,
    // Supply monitor
    input  wire logic        supply_low,
    output logic [7:0]       dq,
    output logic             hsb_pull
);
    logic [7:0]  mem [0:32767];   // Volatile array
    logic [7:0]  last    = 8'h00; // Last byte driven
    logic        auto_en = 1'b1;  // Power-loss store on by default
    logic        lock    = 1'b0;  // Recall lockout
    logic        dirty   = 1'b0;  // Write since last transfer
    int          step, stores, recalls;
    logic [13:0] seq [5] = '{14'h0E38, 14'h31C7, 14'h03E0, 14'h3C1F, 14'h303F};
    initial hsb_pull = 1'b0;
    // Read data only while selected and idle; else bus shows a changed value
    assign dq = (!ce_n && !oe_n && we_n && hsb_n && !lock) ? mem[addr] : ~last;
    wire         wr_act = !ce_n && !we_n; // Select and strobe both low
    logic        wr_ok  = 1'b0;           // Write armed by a fresh falling edge
    // Released bus keeps changing
    always @(posedge ce_n) last <= dq;
    // Only an edge that starts the write arms it, never a level left over
    always @(posedge wr_act) wr_ok = hsb_n && !hsb_pull && !lock;
    // Write ends when select or strobe rises; no race between the two
    always @(negedge wr_act) begin
        if (wr_ok && hsb_n && !hsb_pull && !lock) begin
            mem[addr] = din;
            dirty = 1'b1;
        end
        wr_ok = 1'b0;
    end
    // Sequence detector; a write or a wrong address restarts it
    always @(negedge ce_n) begin
        #1;
        if (!we_n) step = 0;
        else if (step < 5) step = (addr[13:0] == seq[step]) ? step + 1
                                : (addr[13:0] == seq[0]) ? 1 : 0;
        else begin
            step = 0;
            case (addr[13:0])
                14'h03F8: auto_en = 1'b0;
                14'h07F0: auto_en = 1'b1;
                14'h0FC0: begin
                    hsb_pull = 1'b1;
                    stores++;
                    #STORE_NS hsb_pull = 1'b0;
                    dirty = 1'b0;
                end
                14'h0C63: begin
                    lock = 1'b1;
                    recalls++;
                    #RECALL_NS lock = 1'b0;
                    dirty = 1'b0;
                end
                default: ;
            endcase
        end
    end
    // Pin request stores only after a write
    always @(negedge hsb_n) if (!hsb_pull && dirty) begin
        #LAT_NS hsb_pull = 1'b1;
        stores++;
        #STORE_NS hsb_pull = 1'b0;
        dirty = 1'b0;
    end
    // Supply sag stores from the capacitor when enabled and written
    always @(posedge supply_low) if (auto_en && dirty && !hsb_pull) begin
        hsb_pull = 1'b1;
        stores++;
        #STORE_NS hsb_pull = 1'b0;
        dirty = 1'b0;
    end
endmodule // nv_device_model

// >>> tb/tb.sv
// Self-checking bench for the store/recall host controller
`timescale 1ns/1ns
`include "nv_host_defines.svh"
module tb;
    import nv_host_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err_s, sag;
    logic        ce_n, we_n, oe_n, data_oe_n, bo, boe_n, pull;
    logic [7:0]  paddr, data_o, dq;
    logic [31:0] pwdata, prdata, q;
    logic [14:0] mem_addr, a;
    logic [7:0]  mem_m [int];  // Expected array contents
    int          errors, total_checks, cyc, stores_m;
    // Resolved data lines and pulled-up store/busy pin
    wire  [7:0]  data_i = data_oe_n ? dq : data_o;
    wire         hw_store_busy_n    = !((!boe_n && !bo) || pull);
    nvsram_host_ctrl nvsram_host_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n),
        .mem_addr(mem_addr), .data_o(data_o), .data_oe_n(data_oe_n), .data_i(data_i),
        .hw_store_busy_n_o(bo), .hw_store_busy_n_oe_n(boe_n), .hw_store_busy_n_i(hw_store_busy_n));
    nv_device_model nv_device_model_i (.ce_n(ce_n), .we_n(we_n), .oe_n(oe_n),
        .addr(mem_addr), .din(data_i), .hsb_n(hw_store_busy_n), .supply_low(sag), .dq(dq),
        .hsb_pull(pull));
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    // Hang guard
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 40000) begin
            errors++;
            conclude();
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // One APB transfer; waits for pready
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        err_s = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Poll status until idle; a poll limit that runs out is a mismatch
    task automatic idle_wait();
        int n;
        n = 0;
        do begin
            apb(1'b0, `REG_STATUS, 32'h0);
            n++;
        end while (q[0] !== 1'b0 && n < 6000);
        chk({31'h0, q[0]}, 32'h0);
    endtask
    // Issue one operation and poll until idle
    task automatic op(input op_t c, input logic [14:0] ad, input logic [7:0] d);
        apb(1'b1, `REG_ADDR, {17'h0, ad});
        apb(1'b1, `REG_WDATA, {24'h0, d});
        apb(1'b1, `REG_CTRL, {29'h0, c});
        idle_wait();
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, sag} = '0;
        q = $urandom(32'h9d87);
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `REG_STATUS, 32'h0);
        chk(q, 32'h0000_0004);
        apb(1'b0, 8'h40, 32'h0);
        chk({q[30:0], err_s}, 32'h0000_0001);
        for (int i = 0; i < 8; i++) begin
            a = (i == 0) ? 15'h0E38 : (i == 1) ? 15'h4E38 : 15'($urandom);
            mem_m[a] = 8'($urandom);
            op(OP_WRITE, a, mem_m[a]);
        end
        foreach (mem_m[k]) begin
            op(OP_READ, 15'(k), 8'h00);
            apb(1'b0, `REG_RDATA, 32'h0);
            chk(q, {24'h0, mem_m[k]});
        end
        op(OP_AUTO_OFF, 15'h0, 8'h0);
        apb(1'b0, `REG_STATUS, 32'h0);
        chk({30'h0, q[2], nv_device_model_i.auto_en}, 32'h0);
        op(OP_AUTO_ON, 15'h0, 8'h0);
        apb(1'b0, `REG_STATUS, 32'h0);
        chk({30'h0, q[2], nv_device_model_i.auto_en}, 32'h3);
        apb(1'b1, `REG_CTRL, 32'h0000_0005);
        apb(1'b1, `REG_CTRL, 32'h0000_0003);
        apb(1'b0, `REG_STATUS, 32'h0);
        chk(q, 32'h0000_000D);
        idle_wait();
        chk(q, 32'h0000_0004);
        op(OP_RECALL, 15'h0, 8'h0);
        chk(32'(nv_device_model_i.recalls), 32'h1);
        op(OP_STORE, 15'h0, 8'h0);
        stores_m = 1;
        chk(32'(nv_device_model_i.stores), 32'(stores_m));
        op(OP_HW_STORE, 15'h0, 8'h0);
        chk(32'(nv_device_model_i.stores), 32'(stores_m));
        op(OP_WRITE, 15'h0100, 8'h5A);
        op(OP_HW_STORE, 15'h0, 8'h0);
        stores_m++;
        chk(32'(nv_device_model_i.stores), 32'(stores_m));
        op(OP_READ, 15'h0100, 8'h00);
        apb(1'b0, `REG_RDATA, 32'h0);
        chk(q, 32'h0000_005A);
        op(OP_WRITE, 15'h0200, 8'hA5);
        sag <= 1'b1;
        repeat (250) @(posedge pclk);
        stores_m++;
        chk(32'(nv_device_model_i.stores), 32'(stores_m));
        conclude();
    end
endmodule // tb
